// ===== acsp_assertions.sv
/*
 Link checker for the configuration port.
 Assumes host and device ends joined on one acsp_if, CLOCK sampling all.
*/
`timescale 1ns/10ps
`default_nettype none
module acsp_assertions (
	// clocking
	input wire logic CLOCK,
	input wire logic RST_N,
	// link
	input wire logic sclk,
	input wire logic chip_select_n,
	input wire logic host_sdio,
	input wire logic host_sdio_oe,
	input wire logic dev_sdio,
	input wire logic dev_sdio_oe,
	input wire logic sdio
);
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RST_N);

	// quiet clock between select and first rise
	sequence s_lead;
		!sclk [*8];
	endsequence
	// one full high phase, then low again
	sequence s_high;
		sclk [*8] ##1 !sclk;
	endsequence

	chk_cs_release: assert property (chip_select_n [*8] |-> !dev_sdio_oe)
		else $error("device drives data while deselected");
	chk_no_contention: assert property (!(host_sdio_oe && dev_sdio_oe))
		else $error("both ends drive the data wire");
	chk_turn_on_low: assert property ($rose(dev_sdio_oe) |-> !chip_select_n && !sclk)
		else $error("readback turn-around outside a low clock phase");
	chk_sdio_steady: assert property (sclk && $past(sclk) |-> $stable(sdio))
		else $error("data wire moved while shift clock high");
	chk_sclk_framed: assert property ($rose(sclk) |-> !chip_select_n)
		else $error("shift clock rise outside a frame");
	chk_lead_quiet: assert property ($fell(chip_select_n) |-> s_lead)
		else $error("shift clock rose too soon after select");
	chk_high_phase: assert property ($rose(sclk) |-> s_high)
		else $error("shift clock high phase not eight cycles");
	chk_rise_driven: assert property ($rose(sclk) |-> host_sdio_oe || dev_sdio_oe)
		else $error("nobody drives data at a shift clock rise");
	chk_host_hold: assert property ($fell(host_sdio_oe) |-> !sclk)
		else $error("host released the wire in a high phase");
endmodule
`default_nettype wire

// ===== acsp_dev.sv
/*
 Device end of the configuration port: frame decoder, shadowed register
 file with two channels, readback driver. Assumes the link runs far
 slower than CLOCK (at least 8 cycles per shift clock phase).
*/
`timescale 1ns/10ps
`default_nettype none
`include "acsp_map.svh"
module acsp_dev import acsp_pkg::*; (
	// clocking
	input  wire logic       CLOCK,
	input  wire logic       RST_N,
	input  wire logic       CE,
	// link
	acsp_if.dev             LINK,
	// live register view
	input  wire logic [7:0] CFG_INDEX,
	input  wire logic       CFG_CHAN,
	output logic      [7:0] CFG_VALUE,
	output logic            LSB_FIRST
);
	localparam int NL = `ACSP_LOC_COUNT;

	logic         sclk_s;
	logic         cs_n_s;
	logic         sdio_s;
	logic         sclk_q;
	acsp_dev_st_t st;
	logic [15:0]  ish;
	logic [7:0]   bsh;
	logic [7:0]   osh;
	logic [3:0]   bitcnt;
	logic [1:0]   nbytes;
	logic [1:0]   len;
	logic [12:0]  addr;
	acsp_op_t     op;
	logic [1:0]   chidx;
	logic         sdio_o;
	logic         sdio_oe;
	logic [7:0]   shadow [0:1][0:NL-1];
	logic [7:0]   live   [0:1][0:NL-1];

	// pins cross into CLOCK before any use
	// reset to idle pin levels: clock low, deselected, wire pulled high
	acsp_sync #(.W(3), .INIT(3'h3)) u_sync (
		.CLOCK (CLOCK),
		.RST_N (RST_N),
		.CE    (CE),
		.D     ({LINK.sclk, LINK.chip_select_n, LINK.sdio}),
		.Q     ({sclk_s, cs_n_s, sdio_s})
	);

	// edges and decoded events
	wire        rise      = sclk_s & ~sclk_q & ~cs_n_s;
	wire        fall      = ~sclk_s & sclk_q;
	wire [15:0] next_ish  = {ish[14:0], sdio_s};
	wire [7:0]  next_bsh  = LSB_FIRST ? {sdio_s, bsh[7:1]}
		: {bsh[6:0], sdio_s};
	wire        instr_end = (st == DS_INSTR) && rise && (bitcnt == 4'hf);
	wire        byte_end  = (st == DS_DATA) && rise && (bitcnt == 4'h7);
	wire        last_byte = (len != `ACSP_LEN_STREAM)
		&& (nbytes == len);
	wire        wr_fire   = byte_end && (op == ACSP_OP_WRITE);
	wire [12:0] next_addr = addr + 13'h1;
	wire [12:0] rd_addr   = instr_end ? next_ish[12:0] : next_addr;
	wire        wr_low    = (addr[12:8] == 5'h0);
	wire [7:0]  wa        = addr[7:0];

	// effects of a completed write byte
	wire        wr_cfg    = wr_fire && wr_low && (wa == `ACSP_ADDR_CFG);
	wire        wr_chidx  = wr_fire && wr_low && (wa == `ACSP_ADDR_CHIDX);
	wire        soft_rst  = wr_cfg && (next_bsh[`ACSP_CFG_SRST_HI]
		| next_bsh[`ACSP_CFG_SRST_LO]);
	wire        xfer      = wr_fire && wr_low && (wa == `ACSP_ADDR_XFER)
		&& next_bsh[`ACSP_XFER_BIT];
	wire        wr_loc    = wr_fire && wr_low
		&& (wa >= `ACSP_ADDR_LOC_LO) && (wa <= `ACSP_ADDR_LOC_HI);
	wire [7:0]  wloc      = wa - `ACSP_ADDR_LOC_LO;

	// readback value; channel A wins when both index bits set
	wire [7:0]  ra        = rd_addr[7:0];
	wire        rd_low    = (rd_addr[12:8] == 5'h0);
	wire [7:0]  rloc      = ra - `ACSP_ADDR_LOC_LO;
	wire        rd_ch     = ~chidx[0];
	wire [7:0]  cfg_rd    = {1'b0, LSB_FIRST, 1'b0, 2'h3, 1'b0,
		LSB_FIRST, 1'b0};
	wire        rd_is_loc = (ra >= `ACSP_ADDR_LOC_LO)
		&& (ra <= `ACSP_ADDR_LOC_HI);
	wire [7:0]  rd_loc    = shadow[rd_ch][rloc[4:0]];
	wire [7:0]  rd_val    = !rd_low ? 8'h00
		: (ra == `ACSP_ADDR_CFG) ? cfg_rd
		: (ra == `ACSP_ADDR_CHIDX) ? {6'h00, chidx}
		: rd_is_loc ? rd_loc : 8'h00;

	// live view for the user side
	wire [7:0]  vloc      = CFG_INDEX - `ACSP_ADDR_LOC_LO;
	wire        v_is_loc  = (CFG_INDEX >= `ACSP_ADDR_LOC_LO)
		&& (CFG_INDEX <= `ACSP_ADDR_LOC_HI);
	wire [7:0]  next_view = v_is_loc ? live[CFG_CHAN][vloc[4:0]] : 8'h00;

	assign LINK.dev_sdio    = sdio_o;
	assign LINK.dev_sdio_oe = sdio_oe;

	// edge history
	always_ff @(posedge CLOCK) begin
		if (!RST_N)
			sclk_q <= 1'b0;
		else if (CE)
			sclk_q <= sclk_s;
	end

	// frame sequencer, sampled on shift clock rises
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			st     <= DS_IDLE;
			ish    <= 16'h0000;
			bsh    <= 8'h00;
			bitcnt <= 4'h0;
			nbytes <= 2'h0;
			len    <= 2'h0;
			addr   <= 13'h0000;
			op     <= ACSP_OP_WRITE;
		end else if (CE) begin
			if (cs_n_s) begin
				// mid-byte or streaming: frame is over
				if (st == DS_INSTR || bitcnt != 4'h0
					|| len == `ACSP_LEN_STREAM)
					st <= DS_IDLE;
			end else if (rise) begin
				case (st)
					DS_IDLE: begin
						st     <= DS_INSTR;
						ish    <= next_ish;
						bitcnt <= 4'h1;
					end
					DS_INSTR: begin
						ish    <= next_ish;
						bitcnt <= bitcnt + 4'h1;
						if (instr_end) begin
							st     <= DS_DATA;
							op     <= acsp_op_t'(next_ish[`ACSP_OP_POS]);
							len    <= next_ish[`ACSP_LEN_HI_POS:`ACSP_LEN_LO_POS];
							addr   <= next_ish[12:0];
							nbytes <= 2'h0;
							bitcnt <= 4'h0;
						end
					end
					DS_DATA: begin
						bsh    <= next_bsh;
						bitcnt <= bitcnt + 4'h1;
						if (byte_end) begin
							bitcnt <= 4'h0;
							addr   <= next_addr;
							nbytes <= nbytes + 2'h1;
							if (last_byte)
								st <= DS_IDLE;
						end
					end
					default: st <= DS_IDLE;
				endcase
			end
		end
	end

	// readback driver: new bit on each fall, pin released otherwise
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			osh     <= 8'h00;
			sdio_o  <= 1'b0;
			sdio_oe <= 1'b0;
		end else if (CE) begin
			if ((instr_end && next_ish[`ACSP_OP_POS])
				|| (byte_end && op == ACSP_OP_READ))
				osh <= rd_val;
			if (cs_n_s)
				sdio_oe <= 1'b0;
			else if (fall) begin
				sdio_oe <= (st == DS_DATA) && (op == ACSP_OP_READ);
				sdio_o  <= LSB_FIRST ? osh[0] : osh[7];
				osh     <= LSB_FIRST ? {1'b0, osh[7:1]} : {osh[6:0], 1'b0};
			end
		end
	end

	// global configuration; soft reset clears itself
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			LSB_FIRST <= 1'b0;
			chidx     <= `ACSP_CHIDX_RESET;
			CFG_VALUE <= 8'h00;
		end else if (CE) begin
			CFG_VALUE <= next_view;
			if (soft_rst) begin
				LSB_FIRST <= 1'b0;
				chidx     <= `ACSP_CHIDX_RESET;
			end else if (wr_cfg)
				LSB_FIRST <= next_bsh[`ACSP_CFG_LSB_HI]
					| next_bsh[`ACSP_CFG_LSB_LO];
			else if (wr_chidx)
				chidx <= next_bsh[1:0];
		end
	end

	genvar c, i;
	// per channel and entry: shadow write, then transfer to live
	generate
		for (c = 0; c < 2; c++) begin : g_ch
			for (i = 0; i < NL; i++) begin : g_loc
				always_ff @(posedge CLOCK) begin
					if (!RST_N) begin
						shadow[c][i] <= `ACSP_LOC_RESET;
						live[c][i]   <= `ACSP_LOC_RESET;
					end else if (CE) begin
						if (soft_rst) begin
							shadow[c][i] <= `ACSP_LOC_RESET;
							live[c][i]   <= `ACSP_LOC_RESET;
						end else begin
							if (wr_loc && chidx[c] && wloc == 8'(i))
								shadow[c][i] <= next_bsh;
							if (xfer)
								live[c][i] <= shadow[c][i];
						end
					end
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// ===== acsp_host.sv
/*
 Host end of the configuration port: runs one frame per START, making the
 shift clock from CLOCK by a divider. Assumes the device end on the link.
*/
`timescale 1ns/10ps
`default_nettype none
`include "acsp_map.svh"
module acsp_host import acsp_pkg::*; (
	// clocking
	input  wire logic        CLOCK,
	input  wire logic        RST_N,
	input  wire logic        CE,
	// link
	acsp_if.host             LINK,
	// command
	input  wire logic        START,
	input  wire logic        RD,
	input  wire logic [1:0]  LEN,
	input  wire logic [12:0] ADDR,
	input  wire logic [31:0] WDATA,
	input  wire logic        LSB_FIRST,
	// status
	output logic      [31:0] RDATA,
	output logic             BUSY,
	output logic             DONE
);
	localparam logic [3:0] HALF = 4'(`ACSP_SCLK_HALF_CYC);

	acsp_host_st_t st;
	logic [3:0]    hcnt;
	logic [5:0]    bitnum;
	logic [5:0]    last;
	logic [47:0]   tx;
	logic          rd;
	logic          lsb;
	logic          sdio_s;
	logic          sclk;
	logic          cs_n;
	logic          sdio_o;
	logic          sdio_oe;

	acsp_sync #(.W(1), .INIT(1'b1)) u_sync (
		.CLOCK (CLOCK),
		.RST_N (RST_N),
		.CE    (CE),
		.D     (LINK.sdio),
		.Q     (sdio_s)
	);

	// frame image and receive position
	wire [15:0] instr   = {RD, LEN, ADDR};
	wire [31:0] wrev    = {<<{WDATA}};
	// byte0 leaves first; lsb order is the whole word bit-reversed
	wire [31:0] wbytes  = LSB_FIRST ? wrev : {<<8{WDATA}};
	wire        half_up = (hcnt == HALF - 4'h1);
	wire        in_data = (bitnum >= 6'd16);
	wire [5:0]  dbit    = bitnum - 6'd16;
	wire [2:0]  bpos    = lsb ? dbit[2:0] : 3'h7 - dbit[2:0];
	wire [4:0]  rpos    = {dbit[4:3], bpos};

	assign LINK.sclk          = sclk;
	assign LINK.chip_select_n = cs_n;
	assign LINK.host_sdio     = sdio_o;
	assign LINK.host_sdio_oe  = sdio_oe;

	// phase timer
	always_ff @(posedge CLOCK) begin
		if (!RST_N)
			hcnt <= 4'h0;
		else if (CE)
			hcnt <= (st == HS_IDLE || half_up) ? 4'h0 : hcnt + 4'h1;
	end

	// frame sequencer
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			st      <= HS_IDLE;
			bitnum  <= 6'h00;
			last    <= 6'h00;
			tx      <= 48'h0;
			rd      <= 1'b0;
			lsb     <= 1'b0;
			sclk    <= 1'b0;
			cs_n    <= 1'b1;
			sdio_o  <= 1'b0;
			sdio_oe <= 1'b0;
			RDATA   <= 32'h0;
			BUSY    <= 1'b0;
			DONE    <= 1'b0;
		end else if (CE) begin
			DONE <= 1'b0;
			case (st)
				HS_IDLE: if (START) begin
					st     <= HS_LEAD;
					tx     <= {instr, wbytes};
					rd     <= RD;
					lsb    <= LSB_FIRST;
					last   <= 6'd23 + {1'b0, LEN, 3'h0};
					bitnum <= 6'h00;
					cs_n   <= 1'b0;
					BUSY   <= 1'b1;
				end
				HS_LEAD: if (half_up)
					st <= HS_LOW;
				HS_LOW: begin
					// drive on the low phase, the device samples on rise
					sclk    <= 1'b0;
					sdio_o  <= tx[47];
					sdio_oe <= !(rd && in_data);
					if (half_up) begin
						st   <= HS_HIGH;
						sclk <= 1'b1;
					end
				end
				HS_HIGH: if (half_up) begin
					// sample just before the fall, data still stable
					if (rd && in_data)
						RDATA[rpos] <= sdio_s;
					tx     <= {tx[46:0], 1'b0};
					bitnum <= bitnum + 6'h01;
					sclk   <= 1'b0;
					st     <= (bitnum == last) ? HS_TRAIL : HS_LOW;
				end
				HS_TRAIL: begin
					sdio_oe <= 1'b0;
					if (half_up) begin
						cs_n <= 1'b1;
						BUSY <= 1'b0;
						DONE <= 1'b1;
						st   <= HS_IDLE;
					end
				end
				default: st <= HS_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// ===== acsp_if.sv
/*
 Link between host and device: shift clock, chip select and one shared
 data wire. Resolves the wire from both enables; idles high.
*/
`timescale 1ns/10ps
`default_nettype none
interface acsp_if;
	logic sclk;
	logic chip_select_n;
	logic host_sdio;
	logic host_sdio_oe;
	logic dev_sdio;
	logic dev_sdio_oe;
	logic sdio;

	// wire level from enables, pulled high when nobody drives
	assign sdio = host_sdio_oe ? host_sdio : (dev_sdio_oe ? dev_sdio : 1'b1);

	modport host (output sclk, output chip_select_n, output host_sdio,
		output host_sdio_oe, input sdio);
	modport dev (input sclk, input chip_select_n, output dev_sdio,
		output dev_sdio_oe, input sdio);
endinterface
`default_nettype wire

// ===== acsp_map.svh
/*
 Constants of the three-wire configuration port: frame sizes, addresses,
 reset values and link timing. Assumes a 200 MHz system clock.
*/
`ifndef ACSP_MAP_SVH
`define ACSP_MAP_SVH

// frame layout
`define ACSP_INSTR_BITS    16
`define ACSP_BYTE_BITS     8
`define ACSP_OP_POS        15
`define ACSP_LEN_HI_POS    14
`define ACSP_LEN_LO_POS    13
`define ACSP_LEN_STREAM    2'h3

// register addresses
`define ACSP_ADDR_CFG      8'h00
`define ACSP_ADDR_CHIDX    8'h05
`define ACSP_ADDR_XFER     8'hff
`define ACSP_ADDR_LOC_LO   8'h08
`define ACSP_ADDR_LOC_HI   8'h1f
`define ACSP_LOC_COUNT     24

// port configuration fields, both nibbles
`define ACSP_CFG_LSB_HI    6
`define ACSP_CFG_LSB_LO    1
`define ACSP_CFG_SRST_HI   5
`define ACSP_CFG_SRST_LO   2
`define ACSP_CFG_RESET     8'h18
`define ACSP_CHIDX_RESET   2'h3
`define ACSP_LOC_RESET     8'h00
`define ACSP_XFER_BIT      0

// link timing
`define ACSP_CLK_PERIOD_NS 5
`define ACSP_SCLK_HALF_NS  40
`define ACSP_SCLK_HALF_CYC (`ACSP_SCLK_HALF_NS / `ACSP_CLK_PERIOD_NS)

`endif

// ===== acsp_pkg.sv
/*
 Types shared by both ends of the configuration port.
 Assumes acsp_map.svh for all figures.
*/
package acsp_pkg;
	typedef enum logic {ACSP_OP_WRITE, ACSP_OP_READ} acsp_op_t;
	typedef enum {DS_IDLE, DS_INSTR, DS_DATA} acsp_dev_st_t;
	typedef enum {HS_IDLE, HS_LEAD, HS_LOW, HS_HIGH, HS_TRAIL} acsp_host_st_t;
endpackage

// ===== acsp_sync.sv
/*
 Three-stage input synchroniser; output follows once stages two and
 three agree. Assumes inputs asynchronous to CLOCK.
*/
`timescale 1ns/10ps
`default_nettype none
module acsp_sync #(
	parameter int           W    = 1,
	parameter logic [W-1:0] INIT = '0
) (
	// clocking
	input  wire logic         CLOCK,
	input  wire logic         RST_N,
	input  wire logic         CE,
	// data
	input  wire logic [W-1:0] D,
	output logic      [W-1:0] Q
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;

	genvar i;
	// one chain per bit; only s2 reads s1
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge CLOCK) begin
				if (!RST_N) begin
					s1[i] <= INIT[i];
					s2[i] <= INIT[i];
					s3[i] <= INIT[i];
					Q[i]  <= INIT[i];
				end else if (CE) begin
					s1[i] <= D[i];
					s2[i] <= s1[i];
					s3[i] <= s2[i];
					if (s2[i] == s3[i])
						Q[i] <= s3[i];
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// ===== adc_config_serial_port_tb.sv
/*
 Testbench: host and device ends on one link, a second device worked
 by hand for chip select stalls. Assumes acsp_map.svh figures.
*/
`timescale 1ns/10ps
`default_nettype none
module adc_config_serial_port_tb;
	logic        CLOCK, RST_N, start, rd, lsb_first, cfg_chan;
	logic        busy, done, lsb_dev, mlsb;
	logic [1:0]  len, chi;
	logic [12:0] addr;
	logic [31:0] wdata, rdata;
	logic [7:0]  cfg_index, cfg_value, cfg_value2, b0, b1;
	logic [15:0] instr;
	logic [7:0]  shd [2][256];
	logic [7:0]  liv [2][256];
	int          nbit, err_total, comparisons;
	acsp_if link ();
	acsp_if link2 ();

	acsp_host i_acsp_host (.CLOCK(CLOCK), .RST_N(RST_N), .CE(1'b1),
		.LINK(link.host), .START(start), .RD(rd), .LEN(len), .ADDR(addr),
		.WDATA(wdata), .LSB_FIRST(lsb_first), .RDATA(rdata), .BUSY(busy),
		.DONE(done));
	acsp_dev i_acsp_dev (.CLOCK(CLOCK), .RST_N(RST_N), .CE(1'b1),
		.LINK(link.dev), .CFG_INDEX(cfg_index), .CFG_CHAN(cfg_chan),
		.CFG_VALUE(cfg_value), .LSB_FIRST(lsb_dev));
	acsp_dev i_acsp_dev2 (.CLOCK(CLOCK), .RST_N(RST_N), .CE(1'b1),
		.LINK(link2.dev), .CFG_INDEX(cfg_index), .CFG_CHAN(cfg_chan),
		.CFG_VALUE(cfg_value2), .LSB_FIRST());
	acsp_assertions i_acsp_assertions (.CLOCK(CLOCK), .RST_N(RST_N),
		.sclk(link.sclk), .chip_select_n(link.chip_select_n),
		.host_sdio(link.host_sdio), .host_sdio_oe(link.host_sdio_oe),
		.dev_sdio(link.dev_sdio), .dev_sdio_oe(link.dev_sdio_oe),
		.sdio(link.sdio));

	// 200 MHz system clock
	always #2.5 CLOCK = ~CLOCK;

	// wire monitor: instruction bits and frame length
	always @(posedge link.sclk) begin
		if (link.chip_select_n === 1'b0) begin
			if (nbit < 16) instr <= {instr[14:0], link.sdio};
			nbit <= nbit + 1;
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic tally_and_finish();
		if (err_total == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// reference register file
	task automatic model_clear();
		foreach (shd[c, i]) begin
			shd[c][i] = 8'h00;
			liv[c][i] = 8'h00;
		end
		chi = 2'h3;
		mlsb = 1'b0;
	endtask

	function automatic logic [7:0] model_rd(input logic [12:0] a);
		if (a == 13'h0000) return mlsb ? 8'h5a : 8'h18;
		if (a == 13'h0005) return {6'h00, chi};
		if (a >= 13'h0008 && a <= 13'h001f) return shd[chi[0] ? 0 : 1][a[7:0]];
		return 8'h00;
	endfunction

	task automatic model_wr(input logic [12:0] a, input logic [7:0] v);
		if (a == 13'h0000 && (v[5] | v[2])) model_clear();
		else if (a == 13'h0000) mlsb = v[6] | v[1];
		else if (a == 13'h0005) chi = v[1:0];
		else if (a >= 13'h0008 && a <= 13'h001f) begin
			if (chi[0]) shd[0][a[7:0]] = v;
			if (chi[1]) shd[1][a[7:0]] = v;
		end else if (a == 13'h00ff && v[0]) liv = shd;
	endtask

	// one host frame, checked on the wire and against the model
	task automatic xfer(input logic r, input logic [1:0] l,
		input logic [12:0] a, input logic [31:0] wd);
		int i;
		@(posedge CLOCK);
		rd <= r;
		len <= l;
		addr <= a;
		wdata <= wd;
		start <= 1'b1;
		nbit = 0;
		@(posedge CLOCK);
		start <= 1'b0;
		for (i = 0; i < 2000 && done !== 1'b1; i++) @(posedge CLOCK);
		if (i == 2000) begin
			err_total++;
			tally_and_finish();
		end
		chk(busy, 1'b0);
		chk(nbit, 16 + 8 * (l + 1));
		chk(instr, {r, l, a});
		for (i = 0; i <= l; i++) begin
			if (r) chk(rdata[8*i+:8], model_rd(a + 13'(i)));
			else model_wr(a + 13'(i), wd[8*i+:8]);
		end
		lsb_first <= mlsb;
	endtask

	task automatic look(input logic [7:0] a, input logic c);
		cfg_index <= a;
		cfg_chan <= c;
		repeat (2) @(posedge CLOCK);
	endtask

	// hand-driven host on the second link, msb first
	task automatic bb(input logic [23:0] v, input int n);
		for (int i = n - 1; i >= 0; i--) begin
			link2.host_sdio <= v[i];
			link2.sclk <= 1'b0;
			repeat (8) @(posedge CLOCK);
			link2.sclk <= 1'b1;
			repeat (8) @(posedge CLOCK);
		end
		link2.sclk <= 1'b0;
		repeat (8) @(posedge CLOCK);
	endtask

	// released data line idles high; only the undriven host_sdio value toggles behind its enable
	task automatic bb_cs(input logic lvl, input int n);
		link2.chip_select_n <= lvl;
		link2.host_sdio_oe <= ~lvl;
		if (lvl) link2.host_sdio <= ~link2.host_sdio;
		repeat (n) @(posedge CLOCK);
	endtask

	// main sequence
	initial begin
		void'($urandom(33));
		{CLOCK, RST_N, start, rd, lsb_first, cfg_chan, len} = '0;
		{addr, wdata, cfg_index, instr, nbit, err_total, comparisons} = '0;
		{link2.sclk, link2.host_sdio, link2.host_sdio_oe} = '0;
		link2.chip_select_n = 1'b1;
		model_clear();
		repeat (2) @(posedge CLOCK);
		RST_N <= 1'b1;
		chk(lsb_dev, 1'b0);
		xfer(1'b0, 2'h3, 13'h0008, $urandom);
		look(8'h08, 1'b0);
		chk(cfg_value, 8'h00);
		xfer(1'b1, 2'h3, 13'h0008, 32'h0);
		xfer(1'b0, 2'h0, 13'h00ff, 32'h01);
		for (int a = 8; a < 12; a++) begin
			for (int c = 0; c < 2; c++) begin
				look(8'(a), 1'(c));
				chk(cfg_value, liv[c][a]);
			end
		end
		xfer(1'b1, 2'h0, 13'h00ff, 32'h0);
		xfer(1'b0, 2'h0, 13'h0005, 32'h02);
		xfer(1'b0, 2'h1, 13'h0009, $urandom);
		xfer(1'b1, 2'h1, 13'h0009, 32'h0);
		xfer(1'b0, 2'h0, 13'h0005, 32'h03);
		xfer(1'b1, 2'h2, 13'h0008, 32'h0);
		xfer(1'b1, 2'h0, 13'h0000, 32'h0);
		xfer(1'b0, 2'h0, 13'h0108, $urandom);
		xfer(1'b1, 2'h1, 13'h0108, 32'h0);
		xfer(1'b1, 2'h0, 13'h0003, 32'h0);
		xfer(1'b0, 2'h0, 13'h0000, 32'h42);
		chk(lsb_dev, 1'b1);
		xfer(1'b0, 2'h3, 13'h000c, $urandom);
		xfer(1'b1, 2'h3, 13'h000c, 32'h0);
		xfer(1'b1, 2'h0, 13'h0000, 32'h0);
		xfer(1'b0, 2'h0, 13'h0000, 32'h24);
		chk(lsb_dev, 1'b0);
		xfer(1'b1, 2'h0, 13'h0005, 32'h0);
		xfer(1'b1, 2'h1, 13'h000c, 32'h0);
		b0 = 8'($urandom);
		b1 = 8'($urandom);
		bb_cs(1'b0, 8);
		bb({3'b001, 13'h0008, b0}, 24);
		bb_cs(1'b1, 40);
		bb_cs(1'b0, 8);
		bb({16'h0, b1}, 8);
		bb_cs(1'b1, 40);
		bb_cs(1'b0, 8);
		bb({3'b000, 13'h00ff, 8'h01}, 24);
		bb_cs(1'b1, 40);
		look(8'h08, 1'b0);
		chk(cfg_value2, b0);
		look(8'h09, 1'b1);
		chk(cfg_value2, b1);
		tally_and_finish();
	end
endmodule
`default_nettype wire
